/* File: design/nfh_consts.vh */
`ifndef NFH_CONSTS_VH
`define NFH_CONSTS_VH

// page geometry
`define NFH_PAGE_BYTES 2176
`define NFH_MAIN_BYTES 2048
`define NFH_SPARE_BYTES 128
`define NFH_PAGES_PER_BLOCK 64
`define NFH_BLOCKS 2048
// address layout
`define NFH_ADDR_CYCLES 3'd5
`define NFH_COL_HI_MASK 8'h0F
`define NFH_ROW_TOP_MASK 8'h01
// command codes
`define NFH_CMD_READ1 8'h00
`define NFH_CMD_READ2 8'h30
`define NFH_CMD_COLCHG1 8'h05
`define NFH_CMD_COLCHG2 8'hE0
`define NFH_CMD_CACHE_NEXT 8'h31
`define NFH_CMD_CACHE_LAST 8'h3F
`define NFH_CMD_PROG1 8'h80
`define NFH_CMD_PROG2 8'h10
`define NFH_CMD_PROG_CACHE 8'h15
`define NFH_CMD_PROG_MULTI1 8'h11
`define NFH_CMD_PROG_MULTI2 8'h81
`define NFH_CMD_PROG_COLCHG 8'h85
`define NFH_CMD_COPY_READ 8'h3A
`define NFH_CMD_COPY_PROG 8'h8C
`define NFH_CMD_ERASE1 8'h60
`define NFH_CMD_ERASE2 8'hD0
`define NFH_CMD_ID 8'h90
`define NFH_CMD_STATUS 8'h70
`define NFH_CMD_STATUS_MULTI 8'h71
`define NFH_CMD_RESET 8'hFF
// request kinds on the user port
`define NFH_OP_READ 2'd0
`define NFH_OP_CACHE_NEXT 2'd1
`define NFH_OP_CACHE_LAST 2'd2
`define NFH_OP_COLCHG 2'd3
// timing, in ns, and clock period
`define NFH_CLK_NS 100
`define NFH_FETCH_NS 25000
`define NFH_CACHE_BUSY_NS 25000
`define NFH_FETCH_CYC ((`NFH_FETCH_NS + `NFH_CLK_NS - 1) / `NFH_CLK_NS)
`define NFH_CACHE_BUSY_CYC ((`NFH_CACHE_BUSY_NS + `NFH_CLK_NS - 1) / `NFH_CLK_NS)
// strobe phase length in clocks
`define NFH_PHASE_CYC 2'd1
`define NFH_TMO_W 16

`endif

/* File: design/nfh_fifo_mem.v */
module nfh_fifo_mem #(
    parameter WIDTH = 8,
    parameter AW = 3
) (
    // clock
    input wire mclk,
    // write side
    input wire wr_en,
    input wire [AW-1:0] wr_addr,
    input wire [WIDTH-1:0] wr_data,
    // read side
    input wire [AW-1:0] rd_addr,
    output reg [WIDTH-1:0] rd_data_ff
);
    reg [WIDTH-1:0] mem [0:(1<<AW)-1];

    always @(posedge mclk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        rd_data_ff <= mem[rd_addr];
    end
endmodule // nfh_fifo_mem

/* File: design/nfh_fifo.v */
module nfh_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 8,
    parameter AW = 3
) (
    // clock and reset
    input wire mclk,
    input wire sys_rst,
    // fill side
    input wire in_valid,
    output wire in_ready,
    input wire [WIDTH-1:0] in_data,
    // drain side
    output reg out_valid_ff,
    input wire out_ready,
    output wire [WIDTH-1:0] out_data
);
    reg [AW:0] wr_ptr_ff;
    reg [AW:0] rd_ptr_ff;
    wire [AW:0] used = wr_ptr_ff - rd_ptr_ff;
    // the word on show still sits in its slot, so it counts as held
    wire [AW:0] held = used + {{AW{1'b0}}, out_valid_ff};
    wire full = (held == DEPTH[AW:0]);
    wire has_word = (used != {(AW+1){1'b0}});
    // one word is held in the memory output register
    wire take = has_word && (!out_valid_ff || out_ready);
    wire push = in_valid && !full;
    // re-read the shown word while stalled so the output stays put
    wire [AW:0] shown_ptr = take ? rd_ptr_ff : rd_ptr_ff - 1'b1;

    assign in_ready = !full;

    nfh_fifo_mem #(.WIDTH(WIDTH), .AW(AW)) u_mem (
        .mclk(mclk),
        .wr_en(push),
        .wr_addr(wr_ptr_ff[AW-1:0]),
        .wr_data(in_data),
        .rd_addr(shown_ptr[AW-1:0]),
        .rd_data_ff(out_data)
    );

    always @(posedge mclk) begin
        if (sys_rst) begin
            wr_ptr_ff <= {(AW+1){1'b0}};
            rd_ptr_ff <= {(AW+1){1'b0}};
            out_valid_ff <= 1'b0;
        end else begin
            if (push) begin
                wr_ptr_ff <= wr_ptr_ff + 1'b1;
            end
            if (take) begin
                rd_ptr_ff <= rd_ptr_ff + 1'b1;
                out_valid_ff <= 1'b1;
            end else if (out_ready) begin
                out_valid_ff <= 1'b0;
            end
        end
    end
endmodule // nfh_fifo

/* File: design/nfh_host.v */
`include "nfh_consts.vh"

module nfh_host #(
    parameter FETCH_CYC = `NFH_FETCH_CYC,
    parameter CACHE_CYC = `NFH_CACHE_BUSY_CYC,
    parameter DEPTH = 8
) (
    // clock and reset
    input wire mclk,
    input wire sys_rst,
    // user request
    input wire req_valid,
    input wire [1:0] req_op,
    input wire [11:0] req_col,
    input wire [16:0] req_row,
    input wire [11:0] req_len,
    output reg req_ready_ff,
    // user read data
    output reg [7:0] rd_data_ff,
    output reg rd_valid_ff,
    input wire rd_ready,
    output reg done_ff,
    output reg timeout_ff,
    // flash pins
    output reg chip_sel_n_ff,
    output reg cmd_latch_ff,
    output reg addr_latch_ff,
    output reg write_strobe_n_ff,
    output reg read_strobe_n_ff,
    output reg write_prot_n_ff,
    input wire [7:0] byte_port_in,
    output reg [7:0] byte_port_out_ff,
    output reg byte_port_oe_ff,
    input wire ready_busy_out
);
    localparam S_IDLE = 3'd0;
    localparam S_SEND = 3'd1;
    localparam S_WAIT = 3'd2;
    localparam S_READ = 3'd3;
    localparam S_DONE = 3'd4;

    reg [2:0] state_ff;
    reg [2:0] nxt_state;
    // byte sequence to send: up to 8 entries, kind 0 cmd 1 addr
    reg [7:0] seq_byte_ff [0:7];
    reg [7:0] seq_addr_ff;
    reg [2:0] seq_last_ff;
    reg [2:0] seq_idx_ff;
    reg [1:0] phase_ff;
    reg [11:0] left_ff;
    reg wait_busy_ff;
    reg [`NFH_TMO_W-1:0] tmo_ff;
    reg [`NFH_TMO_W-1:0] tmo_lim_ff;
    reg rd_phase_ff;
    reg fifo_in_valid_ff;
    reg [7:0] fifo_in_data_ff;
    wire fifo_in_ready;
    wire fifo_out_valid;
    wire [7:0] fifo_out_data;
    wire pop = fifo_out_valid && (!rd_valid_ff || rd_ready);
    integer i;

    function [11:0] clip_len;
        input [11:0] col;
        input [11:0] len;
        reg [12:0] room;
        begin
            // never read past the spare area end
            room = 13'd`NFH_PAGE_BYTES - {1'b0, col};
            if ({1'b0, len} > room) begin
                clip_len = room[11:0];
            end else begin
                clip_len = len;
            end
        end
    endfunction

    // second column cycle, upper four lines low
    function [7:0] col_hi;
        input [11:0] col;
        begin
            col_hi = {4'h0, col[11:8]};
        end
    endfunction

    nfh_fifo #(.WIDTH(8), .DEPTH(DEPTH), .AW(3)) u_fifo (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .in_valid(fifo_in_valid_ff),
        .in_ready(fifo_in_ready),
        .in_data(fifo_in_data_ff),
        .out_valid_ff(fifo_out_valid),
        .out_ready(!rd_valid_ff || rd_ready),
        .out_data(fifo_out_data)
    );

    always @* begin
        nxt_state = state_ff;
        case (state_ff)
            S_IDLE: if (req_valid && req_ready_ff) nxt_state = S_SEND;
            S_SEND: if (phase_ff == 2'd3 && seq_idx_ff == seq_last_ff) nxt_state = S_WAIT;
            S_WAIT: begin
                if (timeout_ff) begin
                    nxt_state = S_DONE;
                end else if (!wait_busy_ff && ready_busy_out) begin
                    nxt_state = (left_ff == 12'd0) ? S_DONE : S_READ;
                end
            end
            S_READ: if (left_ff == 12'd0 && !rd_phase_ff) nxt_state = S_DONE;
            S_DONE: nxt_state = S_IDLE;
            default: nxt_state = S_IDLE;
        endcase
    end

    always @(posedge mclk) begin
        if (sys_rst) begin
            state_ff <= S_IDLE;
            req_ready_ff <= 1'b0;
            rd_data_ff <= 8'h00;
            rd_valid_ff <= 1'b0;
            done_ff <= 1'b0;
            timeout_ff <= 1'b0;
            chip_sel_n_ff <= 1'b1;
            cmd_latch_ff <= 1'b0;
            addr_latch_ff <= 1'b0;
            write_strobe_n_ff <= 1'b1;
            read_strobe_n_ff <= 1'b1;
            write_prot_n_ff <= 1'b0;
            byte_port_out_ff <= 8'h00;
            byte_port_oe_ff <= 1'b0;
            seq_addr_ff <= 8'h00;
            seq_last_ff <= 3'd0;
            seq_idx_ff <= 3'd0;
            phase_ff <= 2'd0;
            left_ff <= 12'd0;
            wait_busy_ff <= 1'b0;
            tmo_ff <= {`NFH_TMO_W{1'b0}};
            tmo_lim_ff <= {`NFH_TMO_W{1'b0}};
            rd_phase_ff <= 1'b0;
            fifo_in_valid_ff <= 1'b0;
            fifo_in_data_ff <= 8'h00;
            for (i = 0; i < 8; i = i + 1) begin
                seq_byte_ff[i] <= 8'h00;
            end
        end else begin
            state_ff <= nxt_state;
            done_ff <= 1'b0;
            fifo_in_valid_ff <= 1'b0;
            // write protect stays low; this host only reads
            write_prot_n_ff <= 1'b0;
            if (pop) begin
                rd_data_ff <= fifo_out_data;
                rd_valid_ff <= 1'b1;
            end else if (rd_ready) begin
                rd_valid_ff <= 1'b0;
            end
            case (state_ff)
                S_IDLE: begin
                    req_ready_ff <= 1'b1;
                    chip_sel_n_ff <= 1'b1;
                    if (req_valid && req_ready_ff) begin
                        req_ready_ff <= 1'b0;
                        timeout_ff <= 1'b0;
                        chip_sel_n_ff <= 1'b0;
                        seq_idx_ff <= 3'd0;
                        phase_ff <= 2'd0;
                        left_ff <= clip_len(req_col, req_len);
                        wait_busy_ff <= 1'b1;
                        tmo_ff <= {`NFH_TMO_W{1'b0}};
                        tmo_lim_ff <= (req_op == `NFH_OP_READ) ? FETCH_CYC[`NFH_TMO_W-1:0]
                            : CACHE_CYC[`NFH_TMO_W-1:0];
                        case (req_op)
                            `NFH_OP_READ: begin
                                // 00h, five address bytes, 30h; not relied on
                                seq_byte_ff[0] <= `NFH_CMD_READ1;
                                seq_byte_ff[1] <= req_col[7:0];
                                seq_byte_ff[2] <= col_hi(req_col);
                                // page bits in low six bits
                                seq_byte_ff[3] <= req_row[7:0];
                                seq_byte_ff[4] <= req_row[15:8];
                                seq_byte_ff[5] <= {7'h00, req_row[16]};
                                seq_byte_ff[6] <= `NFH_CMD_READ2;
                                seq_addr_ff <= 8'h3E;
                                seq_last_ff <= 3'd6;
                            end
                            `NFH_OP_CACHE_NEXT: begin
                                // next page to cache, column restarts at 0
                                seq_byte_ff[0] <= `NFH_CMD_CACHE_NEXT;
                                seq_addr_ff <= 8'h00;
                                seq_last_ff <= 3'd0;
                                left_ff <= clip_len(12'd0, req_len);
                            end
                            `NFH_OP_CACHE_LAST: begin
                                seq_byte_ff[0] <= `NFH_CMD_CACHE_LAST;
                                seq_addr_ff <= 8'h00;
                                seq_last_ff <= 3'd0;
                                left_ff <= clip_len(12'd0, req_len);
                            end
                            default: begin
                                seq_byte_ff[0] <= `NFH_CMD_COLCHG1;
                                seq_byte_ff[1] <= req_col[7:0];
                                seq_byte_ff[2] <= col_hi(req_col);
                                seq_byte_ff[3] <= `NFH_CMD_COLCHG2;
                                seq_addr_ff <= 8'h06;
                                seq_last_ff <= 3'd3;
                                wait_busy_ff <= 1'b0;
                            end
                        endcase
                    end
                end
                S_SEND: begin
                    phase_ff <= phase_ff + 2'd1;
                    case (phase_ff)
                        2'd0: begin
                            cmd_latch_ff <= !seq_addr_ff[seq_idx_ff];
                            addr_latch_ff <= seq_addr_ff[seq_idx_ff];
                            byte_port_out_ff <= seq_byte_ff[seq_idx_ff];
                            byte_port_oe_ff <= 1'b1;
                        end
                        2'd1: write_strobe_n_ff <= 1'b0;
                        2'd2: write_strobe_n_ff <= 1'b1;
                        default: begin
                            cmd_latch_ff <= 1'b0;
                            addr_latch_ff <= 1'b0;
                            byte_port_oe_ff <= 1'b0;
                            seq_idx_ff <= seq_idx_ff + 3'd1;
                        end
                    endcase
                end
                S_WAIT: begin
                    // strobes idle high while busy; nothing else sent
                    write_strobe_n_ff <= 1'b1;
                    read_strobe_n_ff <= 1'b1;
                    // busy seen first, then its release
                    if (wait_busy_ff) begin
                        if (!ready_busy_out) begin
                            wait_busy_ff <= 1'b0;
                        end
                    end
                    tmo_ff <= tmo_ff + 1'b1;
                    if (tmo_ff >= tmo_lim_ff && !(ready_busy_out && !wait_busy_ff)) begin
                        timeout_ff <= 1'b1;
                    end
                end
                S_READ: begin
                    // strobe low, then sample on rising; FIFO must have room
                    if (!rd_phase_ff) begin
                        if (left_ff != 12'd0 && fifo_in_ready && !fifo_in_valid_ff) begin
                            read_strobe_n_ff <= 1'b0;
                            rd_phase_ff <= 1'b1;
                        end
                    end else begin
                        read_strobe_n_ff <= 1'b1;
                        rd_phase_ff <= 1'b0;
                        fifo_in_valid_ff <= 1'b1;
                        fifo_in_data_ff <= byte_port_in;
                        left_ff <= left_ff - 12'd1;
                    end
                end
                S_DONE: begin
                    // user issues next command only after done
                    done_ff <= 1'b1;
                end
                default: ;
            endcase
        end
    end
endmodule // nfh_host

/* File: tb/nfh_host_assertions.sv */
module nfh_host_checker #(
    parameter FETCH_CYC = 250
) (
    // clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // user side
    input wire logic req_ready_ff,
    input wire logic done_ff,
    input wire logic timeout_ff,
    // flash pins
    input wire logic chip_sel_n_ff,
    input wire logic cmd_latch_ff,
    input wire logic addr_latch_ff,
    input wire logic write_strobe_n_ff,
    input wire logic read_strobe_n_ff,
    input wire logic [7:0] byte_port_out_ff,
    input wire logic byte_port_oe_ff,
    input wire logic ready_busy_out
);
    default clocking @(posedge mclk); endclocking
    default disable iff (sys_rst);
    logic [15:0] busy_len_ff;
    always_ff @(posedge mclk)
        busy_len_ff <= ready_busy_out ? 16'h0000 : busy_len_ff + 16'h0001;

    AST_LATCH_EXCL: assert property (!(cmd_latch_ff && addr_latch_ff))
        else $error("both latches high");
    AST_WE_PULSE: assert property ($fell(write_strobe_n_ff) |=> $rose(write_strobe_n_ff))
        else $error("write strobe low too long");
    AST_WE_SEL: assert property (!write_strobe_n_ff |->
        !chip_sel_n_ff && read_strobe_n_ff && byte_port_oe_ff)
        else $error("write strobe without select or drive");
    AST_DATA_HOLD: assert property (!write_strobe_n_ff |=> $stable(byte_port_out_ff)
        && $stable(cmd_latch_ff) && $stable(addr_latch_ff))
        else $error("byte or latch moved at strobe rise");
    AST_BUSY_QUIET: assert property (!chip_sel_n_ff && !ready_busy_out |->
        write_strobe_n_ff && read_strobe_n_ff)
        else $error("strobe while device busy");
    AST_RE_PULSE: assert property ($fell(read_strobe_n_ff) |=> $rose(read_strobe_n_ff))
        else $error("read strobe low too long");
    AST_RE_BUS: assert property (!read_strobe_n_ff |->
        !byte_port_oe_ff && !cmd_latch_ff && !addr_latch_ff && !chip_sel_n_ff)
        else $error("read strobe with host driving");
    AST_DONE_READY: assert property (done_ff |-> !req_ready_ff ##1 req_ready_ff)
        else $error("ready not back after done");

    cover property ($rose(timeout_ff));
    cover property (done_ff);
    cover property (busy_len_ff == FETCH_CYC);
endmodule // nfh_host_checker

bind nfh_host nfh_host_checker #(.FETCH_CYC(FETCH_CYC)) u_nfh_chk (.*);

/* File: tb/nfh_flash_model.sv */
module nfh_flash_model (
    // host pins
    input wire logic chip_sel_n_ff,
    input wire logic cmd_latch_ff,
    input wire logic addr_latch_ff,
    input wire logic write_strobe_n_ff,
    input wire logic read_strobe_n_ff,
    input wire logic [7:0] byte_port_out_ff,
    input wire logic byte_port_oe_ff,
    output logic [7:0] byte_port_in,
    output logic ready_busy_out = 1'b1,
    // bench control and view
    input wire logic [7:0] busy_cyc,
    output logic [11:0] seen_col,
    output logic [16:0] seen_row,
    output logic [10:0] seen_pad,
    output logic [7:0] odd_cmds = 8'h00
);
    timeunit 1ns;
    timeprecision 1ns;
    // read code held at power on
    logic [7:0] cmd_q = 8'h00;
    logic [7:0] prev = 8'h00;
    logic [7:0] ab [0:4];
    logic [2:0] acnt = 3'd0;
    logic [16:0] crow = 17'h00000;
    logic [16:0] nrow = 17'h00000;
    logic [11:0] ptr = 12'h000;
    logic [7:0] dout = 8'h00;
    assign byte_port_in = byte_port_oe_ff ? byte_port_out_ff : dout;
    task automatic go_busy();
        ready_busy_out = 1'b0;
        #(busy_cyc * 100 + 30);
        ready_busy_out = 1'b1;
    endtask
    always @(posedge write_strobe_n_ff) begin
        if (!chip_sel_n_ff && read_strobe_n_ff && cmd_latch_ff && !addr_latch_ff &&
            (ready_busy_out || byte_port_in inside {8'h70, 8'h71, 8'hFF})) begin
            prev = cmd_q;
            cmd_q = byte_port_in;
            acnt = 3'd0;
            // program, erase, copy and identify codes never expected
            if (cmd_q inside {8'h80, 8'h10, 8'h15, 8'h11, 8'h81, 8'h85, 8'h8C, 8'h60, 8'hD0,
                8'h90, 8'h3A})
                odd_cmds = odd_cmds + 8'h01;
            // address assembly, row is page and block
            if (cmd_q == 8'h30 && prev == 8'h00) begin
                seen_col = {ab[1][3:0], ab[0]};
                seen_row = {ab[4][0], ab[3], ab[2]};
                seen_pad = {ab[1][7:4], ab[4][7:1]};
                crow = seen_row;
                nrow = seen_row + 17'h00001;
                ptr = seen_col;
                go_busy();
            end
            if (cmd_q == 8'hE0 && prev == 8'h05) begin
                seen_col = {ab[1][3:0], ab[0]};
                ptr = seen_col;
            end
            if (cmd_q == 8'h31 || cmd_q == 8'h3F) begin
                crow = nrow;
                nrow = nrow + ((cmd_q == 8'h31) ? 17'h00001 : 17'h00000);
                ptr = 12'h000;
                go_busy();
            end
        end else if (!chip_sel_n_ff && read_strobe_n_ff && addr_latch_ff && !cmd_latch_ff &&
            acnt < 3'd5) begin
            ab[acnt] = byte_port_in;
            acnt = acnt + 3'd1;
        end
    end
    always @(negedge read_strobe_n_ff) begin
        if (!chip_sel_n_ff && ready_busy_out) begin
            dout = crow[7:0] ^ ptr[7:0] ^ {4'h0, ptr[11:8]};
            ptr = ptr + 12'h001;
        end
    end
    // deselected bus must not echo the last byte
    always @(posedge chip_sel_n_ff) dout = ~dout;
endmodule // nfh_flash_model

/* File: tb/nand_command_address_read_port_bench.sv */
module nand_command_address_read_port_bench;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int FETCH = 20;
    logic mclk = 1'b0;
    logic sys_rst = 1'b1;
    logic req_valid = 1'b0;
    logic [1:0] req_op = 2'd0;
    logic [11:0] req_col = 12'h000;
    logic [16:0] req_row = 17'h00000;
    logic [11:0] req_len = 12'h000;
    logic rd_ready = 1'b0;
    logic [7:0] busy_cyc = 8'h06;
    logic [15:0] rnd = 16'hC077;
    logic [16:0] erow = 17'h00000;
    logic [11:0] eptr = 12'h000;
    int failures = 0;
    int checks_done = 0;
    int cycles = 0;
    int got = 0;
    wire req_ready_ff, rd_valid_ff, done_ff, timeout_ff, chip_sel_n_ff, cmd_latch_ff;
    wire addr_latch_ff, write_strobe_n_ff, read_strobe_n_ff, write_prot_n_ff;
    wire byte_port_oe_ff, ready_busy_out;
    wire [7:0] rd_data_ff, byte_port_out_ff, byte_port_in;
    wire [11:0] seen_col;
    wire [16:0] seen_row;
    wire [10:0] seen_pad;
    wire [7:0] odd_cmds;

    nfh_host #(.FETCH_CYC(FETCH), .CACHE_CYC(FETCH), .DEPTH(8)) dut (.*);
    nfh_flash_model u_flash (.*);

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    function automatic logic [7:0] pat(input logic [16:0] r, input logic [11:0] c);
        return r[7:0] ^ c[7:0] ^ {4'h0, c[11:8]};
    endfunction
    task automatic cmp(input string what, input logic [16:0] exp, input logic [16:0] seen);
        checks_done++;
        if (exp !== seen) begin
            failures++;
            $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    task automatic give_verdict();
        if (failures == 0 && checks_done > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    always #50 mclk = ~mclk;
    // reader stalls at random
    always @(negedge mclk) begin
        rnd <= lfsr(rnd);
        rd_ready <= rnd[0] | rnd[5];
    end
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            failures++;
            give_verdict();
        end
        if (rd_valid_ff === 1'b1 && rd_ready === 1'b1) begin
            cmp("byte", {9'h000, pat(erow, eptr)}, {9'h000, rd_data_ff});
            eptr <= eptr + 12'h001;
            got <= got + 1;
        end
    end

    task automatic run_op(input logic [1:0] op, input logic [11:0] col, input logic [16:0] row,
        input logic [11:0] len, input logic [16:0] xrow, input logic [7:0] bsy);
        int n;
        int exp_n;
        exp_n = (2176 - col < len) ? 2176 - col : len;
        @(negedge mclk);
        busy_cyc = bsy;
        erow = xrow;
        eptr = (op == 2'd1 || op == 2'd2) ? 12'h000 : col;
        got = 0;
        req_valid = 1'b1;
        req_op = op;
        req_col = col;
        req_row = row;
        req_len = len;
        for (n = 0; n < 200 && req_ready_ff !== 1'b1; n++) @(negedge mclk);
        @(negedge mclk);
        req_valid = 1'b0;
        for (n = 0; n < 3000 && done_ff !== 1'b1 && timeout_ff !== 1'b1; n++) @(negedge mclk);
        if (bsy > FETCH) begin
            cmp("timeout", 17'h1, {16'h0, timeout_ff});
            return;
        end
        cmp("done timeout", 17'h2, {15'h0, done_ff, timeout_ff});
        // done comes before the FIFO drains; wait for the bytes, then for strays
        for (n = 0; n < 400 && got < exp_n; n++) @(negedge mclk);
        repeat (24) @(negedge mclk);
        cmp("write protect", 17'h0, {16'h0, write_prot_n_ff});
        cmp("count", 17'(exp_n), 17'(got));
        if (op == 2'd0 || op == 2'd3)
            cmp("column", {5'h0, col}, {5'h0, seen_col});
        if (op == 2'd0)
            cmp("row", row, seen_row);
        if (op == 2'd0)
            cmp("pad", 17'h0, {6'h0, seen_pad});
    endtask

    initial begin
        logic [16:0] r;
        repeat (4) @(negedge mclk);
        sys_rst = 1'b0;
        run_op(2'd0, 12'd2175, 17'h1FFFF, 12'd9, 17'h1FFFF, 8'd2);
        for (int i = 0; i < 8; i++) begin
            r = {rnd[1], rnd};
            run_op(2'd0, 12'(rnd % 16'd2176), r, {8'h0, rnd[9:6]} + 12'd1, r, {4'h0, rnd[5:2]} + 8'd2);
        end
        // cached walk over three pages, then a column move
        run_op(2'd0, 12'h010, 17'h0ABCD, 12'd4, 17'h0ABCD, 8'd5);
        run_op(2'd1, 12'h000, 17'h0ABCD, 12'd6, 17'h0ABCE, 8'd3);
        run_op(2'd2, 12'h000, 17'h0ABCD, 12'd6, 17'h0ABCF, 8'd17);
        run_op(2'd3, 12'h87C, 17'h0ABCD, 12'd9, 17'h0ABCF, 8'd2);
        // busy outlasting the bound, then a reset once the device is ready again
        run_op(2'd0, 12'h004, 17'h00040, 12'd2, 17'h00040, 8'd40);
        for (int k = 0; k < 100 && ready_busy_out !== 1'b1; k++) @(negedge mclk);
        sys_rst = 1'b1;
        repeat (4) @(negedge mclk);
        sys_rst = 1'b0;
        run_op(2'd0, 12'h800, 17'h10000, 12'd5, 17'h10000, 8'd19);
        cmp("odd commands", 17'h0, {9'h000, odd_cmds});
        give_verdict();
    end
endmodule // nand_command_address_read_port_bench
